// ### pkg/fapes_pkg.sv
// shared constants, register map and helpers for the flash sequencer
package fapes_pkg;
  // bus clock in MHz
  localparam int CLK_MHZ = 40;
  // minimum waits in ns; counts round up to whole cycles
  localparam int NV_SETUP_NS = 10000;
  localparam int NV_SETUP_CYC = (NV_SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int PROG_SETUP_NS = 5000;
  localparam int PROG_SETUP_CYC = (PROG_SETUP_NS * CLK_MHZ + 999) / 1000;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PROT = 8'h04;
  localparam logic [7:0] OFS_ADDR = 8'h08;
  localparam logic [7:0] OFS_DATA = 8'h0C;
  localparam logic [7:0] OFS_STAT = 8'h10;

  // control field positions
  localparam int BIT_PROG = 0;
  localparam int BIT_ERASE = 1;
  localparam int BIT_MASS = 2;
  localparam int BIT_HV = 3;

  // status field positions
  localparam int BIT_ROW_FAIL = 0;
  localparam int BIT_HV_REFUSED = 1;
  localparam int BIT_SETUP_DONE = 2;
  localparam int BIT_STANDBY = 3;
  localparam int STEP_LSB = 4;

  // values after reset, the no-protect code and the last array address
  localparam logic [7:0] PROT_RESET = 8'hFF;
  localparam logic [15:0] ADDR_RESET = 16'h0000;
  localparam logic [7:0] PROT_NONE = 8'hFF;
  localparam logic [15:0] ARRAY_END = 16'h7FFF;

  // sequence steps, gray coded along the usual path
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_SEL   = 3'b001,
    ST_PROT  = 3'b011,
    ST_LATCH = 3'b010,
    ST_HV    = 3'b110
  } fapes_state_t;

  // row of 64 bytes
  function automatic logic [9:0] row_of(input logic [15:0] a);
    return a[15:6];
  endfunction

  // page of 128 bytes
  function automatic logic [8:0] page_of(input logic [15:0] a);
    return a[15:7];
  endfunction
endpackage

// ### src/fapes_timer.sv
// cycle counter that flags when a minimum wait has elapsed
module fapes_timer #(
  parameter int LIMIT = fapes_pkg::NV_SETUP_CYC
) (
  input wire logic ref_clk,  // bus clock
  input wire logic sys_rst,  // sync reset
  input wire logic start,    // restart the wait
  input wire logic clear,    // abandon the wait
  output logic done          // wait elapsed, level
);
  import fapes_pkg::*;

  localparam int CW = $clog2(LIMIT + 1);

  generate
    if (LIMIT < 1) begin : g_bad
      $error("fapes_timer: LIMIT must be at least one cycle");
    end
  endgenerate

  logic [CW-1:0] cnt;
  logic [CW-1:0] next_cnt;
  logic next_done;

  // count up to the limit and stay there
  always_comb begin
    next_cnt = cnt;
    next_done = done;
    if (clear) begin
      next_cnt = '0;
      next_done = 1'b0;
    end else if (start) begin
      next_cnt = CW'(1);
      next_done = (LIMIT == 1);
    end else if (cnt != '0 && !done) begin
      next_cnt = cnt + CW'(1);
      next_done = (next_cnt == CW'(LIMIT));
    end
  end

  // register the count
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cnt <= '0;
      done <= 1'b0;
    end else begin
      cnt <= next_cnt;
      done <= next_done;
    end
  end
endmodule

// ### src/fapes_protect.sv
// decides whether a target address lies in the protected range
module fapes_protect (
  input wire logic [7:0] prot,   // protection start byte
  input wire logic [15:0] addr,  // target address
  output logic hit               // target is protected
);
  import fapes_pkg::*;

  logic [15:0] start_addr;

  // start is bits 14..7; all ones means nothing protected
  always_comb begin
    start_addr = {1'b0, prot, 7'h00};
    hit = (prot != PROT_NONE) && (addr >= start_addr) &&
          (addr <= ARRAY_END);
  end
endmodule

// ### src/fapes_seq.sv
// flash array program and erase sequencer with apb register access
// Operation
// - erase removes the 128-byte page chosen by the dummy write address
// - programming acts on aligned 64-byte rows
// - writes from another row in one cycle fail
// - dummy write after the protect read latches the address; setup wait before hv
// - wait mode during an operation suspends it into standby
// - stop mode during an operation suspends it into standby
// - in read mode, wait or stop changes nothing
// - standby drives every array control inactive
// - hv sets only with a selection and all prior steps done
// - program and erase select are never both one
// - hv refused when the target lies in the protected range
// - protect byte gives address bits 14..7 of the protected start
module fapes_seq (
  input wire logic ref_clk,                  // bus clock
  input wire logic sys_rst,                  // sync reset
  input wire logic psel,                     // apb select
  input wire logic penable,                  // apb enable
  input wire logic pwrite,                   // apb direction
  input wire logic [7:0] paddr,              // apb byte address
  input wire logic [31:0] pwdata,            // apb write data
  output logic [31:0] prdata,                // apb read data
  output logic pready,                       // apb ready
  output logic pslverr,                      // apb error
  input wire logic wait_mode,                // cpu in wait mode
  input wire logic stop_mode,                // cpu in stop mode
  output logic arr_prog,                     // program select to array
  output logic arr_erase,                    // erase select to array
  output logic arr_mass,                     // whole array select
  output logic arr_hv,                       // charge pump on
  output logic arr_wr,                       // byte write strobe
  output logic [15:0] arr_addr,              // array address
  output logic [7:0] arr_data,               // array data
  output logic standby                       // array in standby
);
  import fapes_pkg::*;

  // control and sequence state
  fapes_state_t state, next_state;
  logic program_select, next_program_select;
  logic erase_select, next_erase_select;
  logic whole_array_select, next_whole_array_select;
  logic high_voltage_enable, next_high_voltage_enable;
  logic [7:0] protect_start_register, next_protect_start_register;
  logic [15:0] target_addr, next_target_addr;
  logic [15:0] latch_addr, next_latch_addr;
  logic row_fail, next_row_fail;
  logic hv_refused, next_hv_refused;
  logic wr_pulse, next_wr_pulse;
  logic [7:0] wr_data, next_wr_data;

  // bus response state
  logic [31:0] rd_q, next_rd_q;
  logic err_q, next_err_q;

  logic acc_wr, acc_rd, setup_phase, low_pwr;
  logic tgt_prot, setup_done, hv_allowed, start_nvs, clr_nvs, hv_deny;
  logic req_prog, req_erase, req_hv, same_row;
  logic [31:0] ctrl_word, stat_word;

  assign acc_wr = psel && penable && pwrite;
  assign acc_rd = psel && penable && !pwrite;
  assign setup_phase = psel && !penable;
  assign low_pwr = wait_mode || stop_mode;

  // requested bits of a control write
  assign req_prog = pwdata[BIT_PROG];
  assign req_erase = pwdata[BIT_ERASE];
  assign req_hv = pwdata[BIT_HV];
  assign same_row = row_of(target_addr) == row_of(latch_addr);

  // protected-range compare on the latched target
  fapes_protect u_protect (
    .prot (protect_start_register),
    .addr (latch_addr),
    .hit  (tgt_prot)
  );

  // nv setup wait runs from the dummy write
  fapes_timer #(
    .LIMIT (NV_SETUP_CYC)
  ) u_nvs (
    .ref_clk (ref_clk),
    .sys_rst (sys_rst),
    .start   (start_nvs),
    .clear   (clr_nvs),
    .done    (setup_done)
  );

  // hv gate also waits the setup time; protected refused
  assign hv_allowed = (state == ST_LATCH) && setup_done && !tgt_prot &&
                      (program_select || erase_select);

  // sequence step and control bits
  always_comb begin
    next_state = state;
    next_program_select = program_select;
    next_erase_select = erase_select;
    next_whole_array_select = whole_array_select;
    next_high_voltage_enable = high_voltage_enable;
    next_protect_start_register = protect_start_register;
    next_target_addr = target_addr;
    next_latch_addr = latch_addr;
    next_row_fail = row_fail;
    next_hv_refused = hv_refused;
    next_wr_pulse = 1'b0;
    next_wr_data = wr_data;
    start_nvs = 1'b0;
    clr_nvs = 1'b0;
    hv_deny = 1'b0;
    if (acc_wr && paddr == OFS_CTRL) begin
      // a write asking for both selects leaves the select and mass bits unchanged
      if (!(req_prog && req_erase)) begin
        next_program_select = req_prog;
        next_erase_select = req_erase;
        next_whole_array_select = pwdata[BIT_MASS];
      end
      if (!req_hv) begin
        next_high_voltage_enable = 1'b0;
      end else if (!high_voltage_enable) begin
        // hv only after select, protect read, write and setup
        if (hv_allowed && (next_program_select || next_erase_select)) begin
          next_high_voltage_enable = 1'b1;
          next_state = ST_HV;
        end else begin
          next_hv_refused = 1'b1;
          hv_deny = 1'b1;
        end
      end
    end
    if (acc_wr && paddr == OFS_PROT) begin
      next_protect_start_register = pwdata[7:0];
    end
    if (acc_wr && paddr == OFS_ADDR) begin
      next_target_addr = pwdata[15:0];
    end
    // a new selection starts a fresh sequence
    if (state == ST_IDLE && (next_program_select || next_erase_select)) begin
      next_state = ST_SEL;
      next_row_fail = 1'b0;
      // a refusal in the same write wins over the clear
      next_hv_refused = hv_deny;
      clr_nvs = 1'b1;
    end
    // protect must be read after selecting
    if (state == ST_SEL && acc_rd && paddr == OFS_PROT) begin
      next_state = ST_PROT;
    end
    if (acc_wr && paddr == OFS_DATA) begin
      if (state == ST_PROT) begin
        // dummy write latches the page or row
        next_latch_addr = target_addr;
        next_state = ST_LATCH;
        start_nvs = 1'b1;
      end else if (state == ST_HV && program_select) begin
        // bytes outside the latched row fail and never reach the array
        if (same_row) begin
          next_wr_pulse = 1'b1;
          next_wr_data = pwdata[7:0];
        end else begin
          next_row_fail = 1'b1;
        end
      end
    end
    // sequence ends once both selects and hv are clear
    if (!next_program_select && !next_erase_select &&
        !next_high_voltage_enable) begin
      next_state = ST_IDLE;
    end
    // a halted cpu issues no writes; outputs gate below
    if (low_pwr && state != ST_IDLE) begin
      next_wr_pulse = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state <= ST_IDLE;
      program_select <= 1'b0;
      erase_select <= 1'b0;
      whole_array_select <= 1'b0;
      high_voltage_enable <= 1'b0;
      protect_start_register <= PROT_RESET;
      target_addr <= ADDR_RESET;
      latch_addr <= ADDR_RESET;
      row_fail <= 1'b0;
      hv_refused <= 1'b0;
      wr_pulse <= 1'b0;
      wr_data <= 8'h00;
    end else begin
      state <= next_state;
      program_select <= next_program_select;
      erase_select <= next_erase_select;
      whole_array_select <= next_whole_array_select;
      high_voltage_enable <= next_high_voltage_enable;
      protect_start_register <= next_protect_start_register;
      target_addr <= next_target_addr;
      latch_addr <= next_latch_addr;
      row_fail <= next_row_fail;
      hv_refused <= next_hv_refused;
      wr_pulse <= next_wr_pulse;
      wr_data <= next_wr_data;
    end
  end

  // standby only while an operation is in progress
  assign standby = low_pwr && (state != ST_IDLE);

  // every array control inactive in standby
  assign arr_prog = program_select && !standby;
  assign arr_erase = erase_select && !standby;
  assign arr_mass = whole_array_select && !standby;
  assign arr_hv = high_voltage_enable && !standby;
  assign arr_wr = wr_pulse && !standby;
  // address steered within the latched row
  assign arr_addr = standby ? 16'h0000 :
                    {latch_addr[15:6], (wr_pulse ? target_addr[5:0] :
                                        latch_addr[5:0])};
  assign arr_data = standby ? 8'h00 : wr_data;

  // readback words
  always_comb begin
    ctrl_word = 32'h0000_0000;
    ctrl_word[BIT_PROG] = program_select;
    ctrl_word[BIT_ERASE] = erase_select;
    ctrl_word[BIT_MASS] = whole_array_select;
    ctrl_word[BIT_HV] = high_voltage_enable;
    stat_word = 32'h0000_0000;
    stat_word[BIT_ROW_FAIL] = row_fail;
    stat_word[BIT_HV_REFUSED] = hv_refused;
    stat_word[BIT_SETUP_DONE] = setup_done;
    stat_word[BIT_STANDBY] = standby;
    stat_word[STEP_LSB +: 3] = state;
  end

  // read data and error captured in the setup phase
  always_comb begin
    next_rd_q = rd_q;
    next_err_q = err_q;
    if (setup_phase) begin
      next_err_q = 1'b0;
      case (paddr)
        OFS_CTRL: next_rd_q = ctrl_word;
        OFS_PROT: next_rd_q = {24'h000000, protect_start_register};
        OFS_ADDR: next_rd_q = {16'h0000, target_addr};
        OFS_DATA: next_rd_q = {24'h000000, wr_data};
        OFS_STAT: next_rd_q = stat_word;
        default: begin
          next_rd_q = 32'h0000_0000;
          next_err_q = 1'b1;
        end
      endcase
    end
  end

  // register the bus answer
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rd_q <= 32'h0000_0000;
      err_q <= 1'b0;
    end else begin
      rd_q <= next_rd_q;
      err_q <= next_err_q;
    end
  end

  // zero wait states: answer in the first access cycle
  assign pready = psel && penable;
  assign prdata = rd_q;
  assign pslverr = psel && penable && err_q;

  // checks on the sequencer
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  sequence foreign_byte_s;
    acc_wr && paddr == OFS_DATA && state == ST_HV && program_select &&
      !same_row && !low_pwr;
  endsequence

  sequence good_byte_s;
    acc_wr && paddr == OFS_DATA && state == ST_HV && program_select &&
      same_row && !low_pwr;
  endsequence

  select_interlock_a: assert property (!(program_select && erase_select))
    else $error("program and erase select both set");
  hv_gate_a: assert property ($rose(high_voltage_enable) |->
    $past(state) == ST_LATCH && $past(setup_done) &&
    (program_select || erase_select))
    else $error("hv set without the prior steps");
  hv_protect_a: assert property ($rose(high_voltage_enable) |->
    !$past(tgt_prot))
    else $error("hv set for a protected target");
  standby_quiet_a: assert property (standby |->
    !arr_hv && !arr_prog && !arr_erase && !arr_mass && !arr_wr)
    else $error("array control active in standby");
  foreign_row_a: assert property (foreign_byte_s |=> row_fail && !arr_wr)
    else $error("foreign row byte not refused");
  row_strobe_a: assert property (good_byte_s |=>
    arr_wr && arr_addr[15:6] == latch_addr[15:6])
    else $error("row byte not strobed within the row");
  idle_lowpwr_a: assert property (state == ST_IDLE && low_pwr |->
    !standby)
    else $error("standby entered from read mode");
  suspend_op_a: assert property (state != ST_IDLE && low_pwr |->
    standby && !arr_hv)
    else $error("operation not suspended in low power");
  prot_start_a: assert property (protect_start_register == 8'h00 &&
    latch_addr[15] == 1'b0 |-> tgt_prot)
    else $error("zero protect byte leaves array open");
endmodule

// ### test/fapes_array_model.sv
// behavioural flash array seen by the sequencer outputs
module fapes_array_model (
  input wire logic ref_clk,          // bus clock
  input wire logic sys_rst,          // sync reset
  input wire logic arr_prog,         // program select
  input wire logic arr_erase,        // erase select
  input wire logic arr_mass,         // whole array select
  input wire logic arr_hv,           // charge pump on
  input wire logic arr_wr,           // byte write strobe
  input wire logic [15:0] arr_addr,  // array address
  input wire logic [7:0] arr_data,   // array data
  input wire logic standby,          // array in standby
  output logic [7:0] wr_count,       // bytes programmed
  output logic [15:0] last_addr,     // last byte address
  output logic [7:0] last_data,      // last byte data
  output logic [8:0] erased_page,    // page under high voltage erase
  output logic idle_bad              // control seen during standby
);
  timeunit 1ns;
  timeprecision 100ps;
  // bench bytes target erased real flash
  // strobes are taken whole at the edge, as the array would latch them
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      wr_count <= 8'h00;
      last_addr <= 16'h0000;
      last_data <= 8'h00;
      erased_page <= 9'h000;
      idle_bad <= 1'b0;
    end else begin
      if (arr_wr) begin
        wr_count <= wr_count + 8'h01;
        last_addr <= arr_addr;
        last_data <= arr_data;
      end
      if (arr_erase && arr_hv && !arr_mass) begin
        erased_page <= arr_addr[15:7];
      end
      if (standby && (arr_prog || arr_erase || arr_mass || arr_hv ||
          arr_wr || (|arr_addr) || (|arr_data))) begin
        idle_bad <= 1'b1;
      end
    end
  end
endmodule

// ### test/flash_array_program_erase_seq_tb.sv
// self-checking bench: cpu register sequences against the flash sequencer
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin \
  fail_count++; $display("[ERR] %0t got %h exp %h", $time, got, exp); \
  end end
module flash_array_program_erase_seq_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import fapes_pkg::*;
  logic ref_clk, sys_rst, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr, arr_data, wr_count, last_data;
  logic [31:0] pwdata, prdata, rd;
  logic wait_mode, stop_mode, arr_prog, arr_erase, arr_mass, arr_hv;
  logic arr_wr, standby, er, idle_bad;
  logic [15:0] arr_addr, last_addr;
  logic [8:0] erased_page;
  int fail_count = 0;
  int checks_done = 0;
  int cyc = 0;

  fapes_seq fapes_seq_i (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .wait_mode(wait_mode), .stop_mode(stop_mode),
    .arr_prog(arr_prog), .arr_erase(arr_erase), .arr_mass(arr_mass),
    .arr_hv(arr_hv), .arr_wr(arr_wr), .arr_addr(arr_addr),
    .arr_data(arr_data), .standby(standby));

  fapes_array_model fapes_array_model_i (.ref_clk(ref_clk),
    .sys_rst(sys_rst), .arr_prog(arr_prog), .arr_erase(arr_erase),
    .arr_mass(arr_mass), .arr_hv(arr_hv), .arr_wr(arr_wr),
    .arr_addr(arr_addr), .arr_data(arr_data), .standby(standby),
    .wr_count(wr_count), .last_addr(last_addr), .last_data(last_data),
    .erased_page(erased_page), .idle_bad(idle_bad));

  // clock at 40 MHz
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  task automatic complete_run();
    if (fail_count == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // hang guard, far above the roughly 1400 cycles the run needs
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 6000) begin
      fail_count++;
      complete_run();
    end
  end

  // one apb transfer; the trailing edge keeps drivers off the same step
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    // wait for ready; only the hang guard ends a stuck wait
    while (pready !== 1'b1) begin
      @(posedge ref_clk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask

  // select, protect read, dummy write, setup wait, then pump on
  task automatic start_op(input logic [31:0] sel, input logic [15:0] a);
    wr(OFS_CTRL, sel);
    apb(1'b0, OFS_PROT, 32'h0);
    wr(OFS_ADDR, {16'h0, a});
    wr(OFS_DATA, 32'h0);
    repeat (NV_SETUP_CYC) @(posedge ref_clk);
    wr(OFS_CTRL, sel | 32'h8);
  endtask

  task automatic pb(input logic [15:0] a, input logic [7:0] d);
    wr(OFS_ADDR, {16'h0, a});
    wr(OFS_DATA, {24'h0, d});
    @(posedge ref_clk);
  endtask

  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    wait_mode = 1'b0;
    stop_mode = 1'b0;
    sys_rst = 1'b1;
    repeat (3) @(posedge ref_clk);
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    `CHK({arr_prog, arr_erase, arr_mass, arr_hv, arr_wr}, 5'h00)
    rdc(OFS_CTRL, 32'h0);
    rdc(OFS_PROT, {24'h0, PROT_RESET});
    wr(OFS_PROT, 32'h0);
    rdc(OFS_PROT, 32'h0);
    wr(OFS_PROT, 32'hFF);
    // unmapped offset answers with an error and zero data
    apb(1'b0, 8'h40, 32'h0);
    `CHK({er, rd}, 33'h100000000)
    wr(OFS_CTRL, 32'h3);
    rdc(OFS_CTRL, 32'h0);
    // bench code sits outside the array
    wr(OFS_CTRL, 32'h9);
    apb(1'b0, OFS_STAT, 32'h0);
    `CHK(rd[BIT_HV_REFUSED], 1'b1)
    wr(OFS_CTRL, 32'h0);
    wr(OFS_CTRL, 32'h1);
    wr(OFS_CTRL, 32'h9);
    `CHK({arr_prog, arr_hv}, 2'h2)
    apb(1'b0, OFS_STAT, 32'h0);
    `CHK(rd[BIT_HV_REFUSED], 1'b1)
    // program one row, pump asked too early first
    rdc(OFS_PROT, 32'hFF);
    wr(OFS_ADDR, 32'h1240);
    wr(OFS_DATA, 32'h0);
    apb(1'b0, OFS_STAT, 32'h0);
    `CHK(rd[6:4], ST_LATCH)
    wr(OFS_CTRL, 32'h9);
    `CHK(arr_hv, 1'b0)
    repeat (NV_SETUP_CYC) @(posedge ref_clk);
    wr(OFS_CTRL, 32'h9);
    `CHK({arr_prog, arr_hv}, 2'h3)
    pb(16'h1245, 8'h5A);
    `CHK({wr_count, last_addr, last_data}, 32'h01_1245_5A)
    pb(16'h127F, 8'hC3);
    `CHK({wr_count, last_addr, last_data}, 32'h02_127F_C3)
    pb(16'h1280, 8'h11);
    `CHK(wr_count, 8'h02)
    apb(1'b0, OFS_STAT, 32'h0);
    `CHK(rd[BIT_ROW_FAIL], 1'b1)
    // wait mode mid-program suspends, then resumes
    wait_mode <= 1'b1;
    repeat (2) @(posedge ref_clk);
    `CHK({standby, arr_prog, arr_hv, arr_addr}, 19'h40000)
    wait_mode <= 1'b0;
    repeat (2) @(posedge ref_clk);
    `CHK({standby, arr_prog, arr_hv}, 3'h3)
    wr(OFS_CTRL, 32'h8);
    wr(OFS_CTRL, 32'h0);
    apb(1'b0, OFS_STAT, 32'h0);
    `CHK(rd[6:4], ST_IDLE)
    stop_mode <= 1'b1;
    repeat (2) @(posedge ref_clk);
    `CHK(standby, 1'b0)
    stop_mode <= 1'b0;
    // protect from 0x1200 up, erase inside it is refused
    wr(OFS_PROT, 32'h24);
    start_op(32'h2, 16'h1280);
    `CHK({arr_erase, arr_hv}, 2'h2)
    wr(OFS_CTRL, 32'h0);
    wr(OFS_PROT, 32'hFF);
    start_op(32'h2, 16'h11C0);
    @(posedge ref_clk);
    `CHK({arr_erase, arr_hv, erased_page}, 11'h623)
    // erase hold shortened, device does not time it
    stop_mode <= 1'b1;
    repeat (2) @(posedge ref_clk);
    `CHK({standby, arr_erase, arr_hv}, 3'h4)
    stop_mode <= 1'b0;
    repeat (2) @(posedge ref_clk);
    `CHK({standby, arr_erase, arr_hv}, 3'h3)
    wr(OFS_CTRL, 32'h8);
    wr(OFS_CTRL, 32'h0);
    `CHK({arr_erase, arr_hv}, 2'h0)
    `CHK(idle_bad, 1'b0)
    complete_run();
  end
endmodule
